// >>> src/gcrb_pkg.sv
// package: offsets, field layout, reset values and rate constants of the chip register bank
package gcrb_pkg;
  localparam int NUM_CHAN = 12;
  localparam int GRP_CHAN = 6;
  localparam int ACC_W = 24;

  // ***********************************************************
  // register offsets
  // ***********************************************************
  localparam logic [7:0] OFS_TX_RED_LO = 8'h00;
  localparam logic [7:0] OFS_RX_RED_LO = 8'h08;
  localparam logic [7:0] OFS_MASK_LO = 8'h60;
  localparam logic [7:0] OFS_FLAGS_LO = 8'h61;
  localparam logic [7:0] OFS_PART_ID = 8'h6e;
  localparam logic [7:0] OFS_SI_REV = 8'h6f;
  localparam logic [7:0] OFS_TX_RED_HI = 8'h80;
  localparam logic [7:0] OFS_RX_RED_HI = 8'h88;
  localparam logic [7:0] OFS_MASK_HI = 8'he0;
  localparam logic [7:0] OFS_FLAGS_HI = 8'he1;

  // ***********************************************************
  // field layout and reset values
  // ***********************************************************
  localparam int CHAN_LSB = 0;
  localparam int CHAN_MSB = 5;
  localparam logic [5:0] RST_GROUP = 6'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  localparam logic [1:0] RSVD_BITS = 2'h0;

  // ***********************************************************
  // line rates, phase increments against the 250 mhz clock
  // ***********************************************************
  typedef enum logic [1:0] {
    GCRB_RATE_DS3,
    GCRB_RATE_E3,
    GCRB_RATE_STS1,
    GCRB_RATE_OFF
  } gcrb_rate_t;

  localparam longint CLK_KHZ = 250000;
  localparam longint DS3_KHZ = 44736;
  localparam longint E3_KHZ = 34368;
  localparam longint STS1_KHZ = 51840;
  localparam longint ACC_SPAN = 64'h1000000;
  localparam logic [ACC_W-1:0] INC_DS3 = ACC_W'((DS3_KHZ * ACC_SPAN) / CLK_KHZ);
  localparam logic [ACC_W-1:0] INC_E3 = ACC_W'((E3_KHZ * ACC_SPAN) / CLK_KHZ);
  localparam logic [ACC_W-1:0] INC_STS1 = ACC_W'((STS1_KHZ * ACC_SPAN) / CLK_KHZ);

  function automatic logic [ACC_W-1:0] rate_inc(input gcrb_rate_t sel);
    case (sel)
      GCRB_RATE_DS3: rate_inc = INC_DS3;
      GCRB_RATE_E3: rate_inc = INC_E3;
      GCRB_RATE_STS1: rate_inc = INC_STS1;
      default: rate_inc = '0;
    endcase
  endfunction : rate_inc

  // a control group byte: reserved bits forced to zero
  function automatic logic [7:0] grp_byte(input logic [5:0] bits);
    grp_byte = {RSVD_BITS, bits};
  endfunction : grp_byte
endpackage : gcrb_pkg

// >>> src/gcrb_line_if.sv
// interface: per-channel transmit enables, rates and bit strobes inside the bank
`timescale 1ns/100ps
`default_nettype none
interface gcrb_line_if;
  import gcrb_pkg::*;
  logic [NUM_CHAN-1:0] tx_on;
  logic [NUM_CHAN-1:0] bit_strobe;
  gcrb_rate_t rate_sel [NUM_CHAN];
  modport ctl (output tx_on, output rate_sel, input bit_strobe);
  modport gen (input tx_on, input rate_sel, output bit_strobe);
endinterface : gcrb_line_if
`default_nettype wire

// >>> src/gcrb_rate_gen.sv
// module: per-channel phase accumulators giving one-cycle line bit strobes
`timescale 1ns/100ps
`default_nettype none
module gcrb_rate_gen
  import gcrb_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic rst, // async reset
  gcrb_line_if.gen line // enables in, strobes out
);
  typedef struct packed {
    logic [NUM_CHAN-1:0][ACC_W-1:0] acc;
    logic [NUM_CHAN-1:0] strobe;
  } gcrb_gen_st_t;

  gcrb_gen_st_t st_q;
  gcrb_gen_st_t st_d;

  always_comb begin
    logic [ACC_W:0] sum;
    sum = '0;
    st_d = st_q;
    for (int i = 0; i < NUM_CHAN; i++) begin
      // an idle channel restarts its phase so the first bit is a full period
      if (line.tx_on[i]) begin
        sum = {1'b0, st_q.acc[i]} + {1'b0, rate_inc(line.rate_sel[i])};
        st_d.acc[i] = sum[ACC_W-1:0];
        st_d.strobe[i] = sum[ACC_W];
      end else begin
        st_d.acc[i] = '0;
        st_d.strobe[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign line.bit_strobe = st_q.strobe;
endmodule : gcrb_rate_gen
`default_nettype wire

// >>> src/gcrb_rx_gate.sv
// module: receiver front end, samples line inputs only while a receiver is on
`timescale 1ns/100ps
`default_nettype none
module gcrb_rx_gate #(
  parameter int N = 12
) (
  input wire logic ref_clk, // system clock
  input wire logic rst, // async reset
  input wire logic [N-1:0] rx_on, // receiver enables
  input wire logic [N-1:0] in_pos, // line input, positive rail
  input wire logic [N-1:0] in_neg, // line input, negative rail
  output logic [N-1:0] out_pos, // registered positive data
  output logic [N-1:0] out_neg // registered negative data
);
  typedef struct packed {
    logic [N-1:0] pos;
    logic [N-1:0] neg;
  } gcrb_rx_st_t;

  gcrb_rx_st_t st_q;
  gcrb_rx_st_t st_d;

  always_comb begin
    st_d.pos = in_pos & rx_on;
    st_d.neg = in_neg & rx_on;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign out_pos = st_q.pos;
  assign out_neg = st_q.neg;
endmodule : gcrb_rx_gate
`default_nettype wire

// >>> src/gcrb_top.sv
// module: chip-level register bank with host port, line drivers and receiver gating
// Functional notes
// - ten chip-level registers, apart from channel groups
// - transmit enables channels 0-5 at 0x00
// - transmit enables channels 6-11 at 0x80
// - receive enables channels 0-5 at 0x08
// - receive enables channels 6-11 at 0x88
// - enable low: driver off, outputs floated
// - enable high: driver on, per channel
// - driver on sends pulses at channel rate
// - master transmit pin must be high
// - interrupt enables channels 0-5 at 0x60
// - interrupt status channels 0-5 at 0x61
// - interrupt enables channels 6-11 at 0xe0
// - interrupt status 6-11 at 0xe1, read-only
// - fixed part code at 0x6e
// - fixed revision code at 0x6f
// - receive enable gates receiver and inputs
// - receive bits 7,6 reserved, 5-0 channels
`timescale 1ns/100ps
`default_nettype none
module gcrb_top
  import gcrb_pkg::*;
#(
  parameter logic [7:0] PART_ID_VAL = 8'h5a, // arbitrary value
  parameter logic [7:0] SI_REV_VAL = 8'h01 // arbitrary value
) (
  input wire logic ref_clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic host_cs, // host port select
  input wire logic host_wr, // host write strobe
  input wire logic host_rd, // host read strobe
  input wire logic [7:0] host_addr, // host register offset
  input wire logic [7:0] host_wdata, // host write data
  output logic [7:0] host_rdata, // host read data
  output logic host_ack, // access done pulse
  input wire logic tx_master_enable, // master transmit pin
  input wire logic [23:0] chan_rate, // two rate bits per channel
  input wire logic [11:0] tx_pos_bit, // next positive-rail bit
  input wire logic [11:0] tx_neg_bit, // next negative-rail bit
  output logic [11:0] tx_bit_taken, // pulse, bit consumed
  output logic [11:0] line_out_pos, // line output, positive
  output logic [11:0] line_out_neg, // line output, negative
  output logic [11:0] line_out_oe, // line output enable
  output logic [11:0] tx_driver_enable, // driver actually on
  output logic [11:0] rx_receiver_enable, // receiver on
  input wire logic [11:0] line_in_pos, // line input, positive
  input wire logic [11:0] line_in_neg, // line input, negative
  output logic [11:0] rx_pos_data, // received positive data
  output logic [11:0] rx_neg_data, // received negative data
  input wire logic [11:0] chan_irq_src, // channel interrupt sources
  output logic [11:0] chan_irq_active // masked channel interrupts
);

  // ***********************************************************
  // state
  // ***********************************************************
  typedef struct packed {
    logic [5:0] tx_red_lo;
    logic [5:0] tx_red_hi;
    logic [5:0] rx_red_lo;
    logic [5:0] rx_red_hi;
    logic [5:0] mask_lo;
    logic [5:0] mask_hi;
    logic [5:0] flags_lo;
    logic [5:0] flags_hi;
    logic [7:0] rdata;
    logic ack;
    logic [NUM_CHAN-1:0] out_pos;
    logic [NUM_CHAN-1:0] out_neg;
    logic [NUM_CHAN-1:0] out_oe;
    logic [NUM_CHAN-1:0] drv_on;
    logic [NUM_CHAN-1:0] taken;
  } gcrb_top_st_t;

  gcrb_top_st_t st_q;
  gcrb_top_st_t st_d;

  gcrb_line_if line ();

  logic wr_stb;
  logic rd_stb;
  logic [NUM_CHAN-1:0] tx_all;
  logic [NUM_CHAN-1:0] rx_all;
  logic [NUM_CHAN-1:0] tx_eff;
  logic [NUM_CHAN-1:0] flags_all;
  logic [7:0] rd_mux;

  // ***********************************************************
  // host port decode
  // ***********************************************************
  // a strobe with both wr and rd high is taken as a write only
  assign wr_stb = host_cs & host_wr;
  assign rd_stb = host_cs & host_rd & ~host_wr;

  assign tx_all = {st_q.tx_red_hi, st_q.tx_red_lo};
  assign rx_all = {st_q.rx_red_hi, st_q.rx_red_lo};
  assign flags_all = {st_q.flags_hi, st_q.flags_lo};

  // the master pin is combined here so dropping it floats every line at once
  assign tx_eff = tx_all & {NUM_CHAN{tx_master_enable}};

  // ***********************************************************
  // read multiplexer
  // ***********************************************************
  always_comb begin
    case (host_addr)
      OFS_TX_RED_LO: begin
        rd_mux = grp_byte(st_q.tx_red_lo);
      end
      OFS_TX_RED_HI: begin
        rd_mux = grp_byte(st_q.tx_red_hi);
      end
      OFS_RX_RED_LO: begin
        rd_mux = grp_byte(st_q.rx_red_lo);
      end
      OFS_RX_RED_HI: begin
        rd_mux = grp_byte(st_q.rx_red_hi);
      end
      OFS_MASK_LO: begin
        rd_mux = grp_byte(st_q.mask_lo);
      end
      OFS_FLAGS_LO: begin
        rd_mux = grp_byte(st_q.flags_lo);
      end
      OFS_MASK_HI: begin
        rd_mux = grp_byte(st_q.mask_hi);
      end
      OFS_FLAGS_HI: begin
        rd_mux = grp_byte(st_q.flags_hi);
      end
      OFS_PART_ID: begin
        rd_mux = PART_ID_VAL;
      end
      OFS_SI_REV: begin
        rd_mux = SI_REV_VAL;
      end
      default: begin
        // only the ten chip-level offsets answer here
        rd_mux = RD_UNMAPPED;
      end
    endcase
  end

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb begin
    st_d = st_q;
    st_d.ack = wr_stb | rd_stb;
    if (rd_stb) begin
      st_d.rdata = rd_mux;
    end

    // writes; flag, part and revision offsets are read-only and fall through
    if (wr_stb) begin
      case (host_addr)
        OFS_TX_RED_LO: begin
          st_d.tx_red_lo = host_wdata[CHAN_MSB:CHAN_LSB];
        end
        OFS_TX_RED_HI: begin
          st_d.tx_red_hi = host_wdata[CHAN_MSB:CHAN_LSB];
        end
        OFS_RX_RED_LO: begin
          st_d.rx_red_lo = host_wdata[CHAN_MSB:CHAN_LSB];
        end
        OFS_RX_RED_HI: begin
          st_d.rx_red_hi = host_wdata[CHAN_MSB:CHAN_LSB];
        end
        OFS_MASK_LO: begin
          st_d.mask_lo = host_wdata[CHAN_MSB:CHAN_LSB];
        end
        OFS_MASK_HI: begin
          st_d.mask_hi = host_wdata[CHAN_MSB:CHAN_LSB];
        end
        default: begin
          // writes to read-only or unmapped offsets change nothing
          st_d.ack = 1'b1;
        end
      endcase
    end

    // status follows the live source; no latching, the channel owns the clear
    st_d.flags_lo = chan_irq_src[GRP_CHAN-1:0] & st_q.mask_lo;
    st_d.flags_hi = chan_irq_src[NUM_CHAN-1:GRP_CHAN] & st_q.mask_hi;

    // line output stage
    st_d.drv_on = tx_eff;
    st_d.taken = '0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (tx_eff[i]) begin
        st_d.out_oe[i] = 1'b1;
        if (line.bit_strobe[i]) begin
          st_d.out_pos[i] = tx_pos_bit[i];
          st_d.out_neg[i] = tx_neg_bit[i];
          st_d.taken[i] = 1'b1;
        end
      end else begin
        // floated and parked low so a re-enable never starts mid-pulse
        st_d.out_oe[i] = 1'b0;
        st_d.out_pos[i] = 1'b0;
        st_d.out_neg[i] = 1'b0;
      end
    end
  end

  // ***********************************************************
  // registers
  // ***********************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
      st_q.tx_red_lo <= RST_GROUP;
      st_q.tx_red_hi <= RST_GROUP;
      st_q.rx_red_lo <= RST_GROUP;
      st_q.rx_red_hi <= RST_GROUP;
      st_q.mask_lo <= RST_GROUP;
      st_q.mask_hi <= RST_GROUP;
    end else begin
      st_q <= st_d;
    end
  end

  // ***********************************************************
  // rate generator and receiver gating
  // ***********************************************************
  assign line.tx_on = tx_eff;

  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_rate
    assign line.rate_sel[g] = gcrb_rate_t'(chan_rate[2*g +: 2]);
  end

  gcrb_rate_gen u_rate_gen (
    .ref_clk(ref_clk),
    .rst(rst),
    .line(line.gen)
  );

  gcrb_rx_gate #(
    .N(NUM_CHAN)
  ) u_rx_gate (
    .ref_clk(ref_clk),
    .rst(rst),
    .rx_on(rx_all),
    .in_pos(line_in_pos),
    .in_neg(line_in_neg),
    .out_pos(rx_pos_data),
    .out_neg(rx_neg_data)
  );

  // ***********************************************************
  // outputs
  // ***********************************************************
  assign host_rdata = st_q.rdata;
  assign host_ack = st_q.ack;
  assign tx_bit_taken = st_q.taken;
  assign line_out_pos = st_q.out_pos;
  assign line_out_neg = st_q.out_neg;
  assign line_out_oe = st_q.out_oe;
  assign tx_driver_enable = st_q.drv_on;
  assign rx_receiver_enable = rx_all;
  assign chan_irq_active = flags_all;

endmodule : gcrb_top
`default_nettype wire

// >>> verif/gcrb_host_model.sv
// partner model: host processor on the register port, also owning the master transmit pin
`timescale 1ns/100ps
`default_nettype none
module gcrb_host_model (
  input wire logic ref_clk, // clock
  output logic host_cs, // select
  output logic host_wr, // write strobe
  output logic host_rd, // read strobe
  output logic [7:0] host_addr, // offset
  output logic [7:0] host_wdata, // write data
  input wire logic [7:0] host_rdata, // read data
  input wire logic host_ack, // done
  output logic tx_master_enable // master pin
);
  initial begin
    host_cs = 1'b0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 8'h00;
    host_wdata = 8'h00;
    tx_master_enable = 1'b0;
  end

  // request held until the ack edge; a lost ack leaves x in q so the caller sees it
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    q = 8'hxx;
    @(posedge ref_clk);
    host_cs <= 1'b1;
    host_wr <= wr;
    host_rd <= !wr;
    host_addr <= a;
    host_wdata <= d;
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      if (host_ack === 1'b1) begin
        q = host_rdata;
        break;
      end
    end
    host_cs <= 1'b0;
    host_wr <= 1'b0;
    host_rd <= 1'b0;
    // released bus shows inverted leftovers, not a stale copy
    host_addr <= ~a;
    host_wdata <= ~d;
  endtask : acc

  task automatic master(input logic v);
    @(posedge ref_clk);
    tx_master_enable <= v;
  endtask : master
endmodule : gcrb_host_model
`default_nettype wire

// >>> verif/gcrb_top_sva.sv
// checker: host port, line driver, receiver and flag relations of the register bank
`timescale 1ns/100ps
`default_nettype none
module gcrb_top_sva #(
  parameter logic [7:0] PART_ID_VAL = 8'h5a // arbitrary value
) (
  input wire logic ref_clk, // clock
  input wire logic rst, // reset
  input wire logic host_cs, // select
  input wire logic host_wr, // write
  input wire logic host_rd, // read
  input wire logic [7:0] host_addr, // offset
  input wire logic [7:0] host_rdata, // read data
  input wire logic host_ack, // done
  input wire logic tx_master_enable, // master pin
  input wire logic [11:0] tx_bit_taken, // bit used
  input wire logic [11:0] line_out_pos, // line out
  input wire logic [11:0] line_out_neg, // line out
  input wire logic [11:0] line_out_oe, // line enable
  input wire logic [11:0] tx_driver_enable, // driver on
  input wire logic [11:0] rx_receiver_enable, // receiver on
  input wire logic [11:0] line_in_pos, // line in
  input wire logic [11:0] rx_pos_data, // rx data
  input wire logic [11:0] chan_irq_src, // sources
  input wire logic [11:0] chan_irq_active // flags
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic acc;
  logic rd;
  assign acc = host_cs && (host_wr || host_rd);
  assign rd = host_cs && host_rd && !host_wr;

  ack_follows_a: assert property (acc |=> host_ack)
    else $error("no ack after access");
  ack_idle_a: assert property (!acc |=> !host_ack)
    else $error("ack without access");
  part_code_a: assert property (
    rd && host_addr == 8'h6e |=> host_rdata == PART_ID_VAL)
    else $error("wrong part code");
  rsvd_zero_a: assert property (
    rd && host_addr[6:0] inside {7'h00, 7'h08, 7'h60, 7'h61} |=> host_rdata[7:6] == 2'h0)
    else $error("reserved bits set");
  master_gate_a: assert property (!tx_master_enable |=> tx_driver_enable == '0)
    else $error("driver on without master");
  oe_match_a: assert property (line_out_oe == tx_driver_enable)
    else $error("oe differs from driver state");
  float_zero_a: assert property (
    ((line_out_pos | line_out_neg) & ~line_out_oe) == '0)
    else $error("data on floated output");
  taken_quiet_a: assert property ((!tx_master_enable) [*3] |-> tx_bit_taken == '0)
    else $error("bit taken with master low");
  rx_gate_a: assert property (
    rx_pos_data == $past(line_in_pos & rx_receiver_enable))
    else $error("rx data not gated");
  irq_src_a: assert property ((chan_irq_active & ~$past(chan_irq_src)) == '0)
    else $error("flag without source");

  wr_cov: cover property (host_cs && host_wr);
  drv_cov: cover property (tx_bit_taken[0]);
  irq_cov: cover property (chan_irq_active != '0);
endmodule : gcrb_top_sva

bind gcrb_top gcrb_top_sva #(.PART_ID_VAL(PART_ID_VAL)) chk (.ref_clk, .rst, .host_cs,
  .host_wr, .host_rd, .host_addr, .host_rdata, .host_ack, .tx_master_enable, .tx_bit_taken,
  .line_out_pos, .line_out_neg, .line_out_oe, .tx_driver_enable, .rx_receiver_enable,
  .line_in_pos, .rx_pos_data, .chan_irq_src, .chan_irq_active);
`default_nettype wire

// >>> verif/gcrb_top_test.sv
// testbench: register map, line enables, receivers and interrupt flags of the register bank
`timescale 1ns/100ps
`default_nettype none
module gcrb_top_test;
  import gcrb_pkg::*;
  localparam logic [7:0] PID = 8'ha5; // arbitrary value
  localparam logic [7:0] REV = 8'h3c; // arbitrary value
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic host_cs, host_wr, host_rd, host_ack, tx_master_enable;
  logic [7:0] host_addr, host_wdata, host_rdata, q;
  logic [23:0] chan_rate = 24'h000000;
  logic [11:0] tx_pos_bit = 12'hfff;
  logic [11:0] tx_neg_bit = 12'h000;
  logic [11:0] line_in_pos = 12'hfff;
  logic [11:0] line_in_neg = 12'h0f0;
  logic [11:0] chan_irq_src = 12'h000;
  logic [11:0] tx_bit_taken, line_out_pos, line_out_neg, line_out_oe, tx_driver_enable;
  logic [11:0] rx_receiver_enable, rx_pos_data, rx_neg_data, chan_irq_active;
  int failures = 0;
  int checks_done = 0;
  int n;
  int c0, c1, c6;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} gcrb_row_t;
  gcrb_row_t rows [11] = '{
    '{8'h00, 8'hff, 8'h3f},
    '{8'h80, 8'hea, 8'h2a},
    '{8'h08, 8'hc5, 8'h05},
    '{8'h88, 8'h7f, 8'h3f},
    '{8'h60, 8'hff, 8'h3f},
    '{8'he0, 8'hd5, 8'h15},
    '{8'h61, 8'hff, 8'h00},
    '{8'he1, 8'hff, 8'h00},
    '{8'h6e, 8'h00, PID},
    '{8'h6f, 8'hff, REV},
    '{8'h01, 8'hff, 8'h00}};

  always #2 ref_clk = ~ref_clk;

  gcrb_host_model hm (.ref_clk, .host_cs, .host_wr, .host_rd, .host_addr, .host_wdata,
    .host_rdata, .host_ack, .tx_master_enable);

  gcrb_top #(.PART_ID_VAL(PID), .SI_REV_VAL(REV)) uut (.ref_clk, .rst, .host_cs, .host_wr,
    .host_rd, .host_addr, .host_wdata, .host_rdata, .host_ack, .tx_master_enable, .chan_rate,
    .tx_pos_bit, .tx_neg_bit, .tx_bit_taken, .line_out_pos, .line_out_neg, .line_out_oe,
    .tx_driver_enable, .rx_receiver_enable, .line_in_pos, .line_in_neg, .rx_pos_data,
    .rx_neg_data, .chan_irq_src, .chan_irq_active);

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  // reads never trust the write just made; each value is read back separately
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    hm.acc(1'b0, a, 8'h00, q);
    chk(12'(q), 12'(e));
  endtask : rd_chk

  // strobes over 1000 cycles against the nominal rate; one count of phase slack allowed
  task automatic rate_chk(input int cnt, input longint khz);
    longint d;
    d = longint'(cnt) - (khz * 1000) / CLK_KHZ;
    chk(12'(d == 0 || d == 1), 12'h001);
  endtask : rate_chk

  initial begin
    repeat (3000) @(posedge ref_clk);
    failures++;
    finish_test();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      hm.acc(1'b1, rows[i].a, rows[i].d, q);
      rd_chk(rows[i].a, rows[i].e);
    end
    $display("test register map done");
    hm.acc(1'b1, 8'h00, 8'h01, q);
    hm.acc(1'b1, 8'h80, 8'h01, q);
    hm.master(1'b1);
    repeat (3) @(posedge ref_clk);
    chk(tx_driver_enable, 12'h041);
    chk(line_out_oe, 12'h041);
    for (n = 0; n < 30 && tx_bit_taken[0] !== 1'b1; n++) @(posedge ref_clk);
    chk(12'(n < 30), 12'h001);
    chk({10'h000, line_out_pos[0], line_out_neg[0]}, 12'h002);
    // ds3 on channel 0, e3 on channel 1, sts-1 on channel 6
    chan_rate <= 24'h002004;
    hm.acc(1'b1, 8'h00, 8'h03, q);
    c0 = 0;
    c1 = 0;
    c6 = 0;
    repeat (1000) begin
      @(posedge ref_clk);
      c0 += int'(tx_bit_taken[0]);
      c1 += int'(tx_bit_taken[1]);
      c6 += int'(tx_bit_taken[6]);
    end
    rate_chk(c0, DS3_KHZ);
    rate_chk(c1, E3_KHZ);
    rate_chk(c6, STS1_KHZ);
    hm.master(1'b0);
    repeat (3) @(posedge ref_clk);
    chk(tx_driver_enable, 12'h000);
    chk(line_out_oe | line_out_pos | line_out_neg, 12'h000);
    $display("test line drivers done");
    hm.acc(1'b1, 8'h08, 8'h2a, q);
    hm.acc(1'b1, 8'h88, 8'h15, q);
    repeat (3) @(posedge ref_clk);
    chk(rx_receiver_enable, 12'h56a);
    chk(rx_pos_data, 12'h56a);
    chk(rx_neg_data, 12'h060);
    $display("test receivers done");
    @(posedge ref_clk);
    chan_irq_src <= 12'hfff;
    rd_chk(8'h61, 8'h3f);
    rd_chk(8'he1, 8'h15);
    chk(chan_irq_active, 12'h57f);
    chan_irq_src <= 12'h0c3;
    repeat (2) @(posedge ref_clk);
    chk(chan_irq_active, 12'h043);
    $display("test interrupt flags done");
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd_chk(rows[i].a, 8'h00);
    chk(tx_driver_enable | rx_receiver_enable | chan_irq_active, 12'h000);
    $display("test reset values done");
    finish_test();
  end
endmodule : gcrb_top_test
`default_nettype wire
